// ---- design/lrp_regs.svh ----
`ifndef LRP_REGS_SVH
`define LRP_REGS_SVH

// ==========================================================================
// register indices (byte address = 4 * index)
// ==========================================================================
`define LRP_IDX_RANK_USE      14'h044d
`define LRP_IDX_BW_LOW        14'h044e
`define LRP_IDX_BW_HIGH       14'h044f
`define LRP_IDX_FILTER        14'h0450
`define LRP_IDX_INT_LOW       14'h0451
`define LRP_IDX_INT_MID       14'h0452
`define LRP_IDX_INT_TOP       14'h0453
`define LRP_IDX_NUM_LOW       14'h0454
`define LRP_IDX_NUM_MID       14'h0455
`define LRP_IDX_NUM_HIGH      14'h0456
`define LRP_IDX_MOD_LOW       14'h0457
`define LRP_IDX_MOD_MID       14'h0458
`define LRP_IDX_MOD_HIGH      14'h0459
`define LRP_NUM_REGS          13
`define LRP_ADDR_W            16

// ==========================================================================
// reset values, per slot 0..12
// ==========================================================================
`define LRP_RST_RANK_USE      8'h01
`define LRP_RST_BW_LOW        8'hf4
`define LRP_RST_BW_HIGH       8'h01
`define LRP_RST_FILTER        8'h00
`define LRP_RST_INT_LOW       8'hcb
`define LRP_RST_INT_MID       8'h07
`define LRP_RST_INT_TOP       8'h00
`define LRP_RST_NUM_LOW       8'h04
`define LRP_RST_NUM_MID       8'h00
`define LRP_RST_NUM_HIGH      8'h00
`define LRP_RST_MOD_LOW       8'h05
`define LRP_RST_MOD_MID       8'h00
`define LRP_RST_MOD_HIGH      8'h00
`define LRP_RST_BW_WORD       16'h01f4
`define LRP_RST_INT_WORD      17'h007cb

// ==========================================================================
// implemented-bit masks and field positions
// ==========================================================================
`define LRP_MASK_RANK_USE     8'h07
`define LRP_MASK_FULL         8'hff
`define LRP_MASK_FILTER       8'h02
`define LRP_MASK_INT_TOP      8'h01
`define LRP_MASK_FRAC_HIGH    8'h7f
`define LRP_USE_BIT           0
`define LRP_RANK_LSB          1
`define LRP_RANK_MSB          2
`define LRP_FILTER_BIT        1
`define LRP_FRAC_RSV_BIT      7

// ==========================================================================
// bus answers
// ==========================================================================
`define LRP_RESP_OKAY         2'b00
`define LRP_RESP_SLVERR       2'b10

`endif

// ---- design/lrp_pkg.sv ----
package lrp_pkg;

   typedef enum logic [1:0] {
      LRP_WR_COLLECT = 2'b01,
      LRP_WR_RESP    = 2'b10
   } lrp_wr_state_t;

   typedef enum logic [1:0] {
      LRP_RD_IDLE  = 2'b01,
      LRP_RD_VALID = 2'b10
   } lrp_rd_state_t;

   typedef struct packed {
      logic [7:0] val;
   } lrp_cell_t;

   typedef struct packed {
      lrp_wr_state_t wr;
      logic          aw_got;
      logic [15:0]   awaddr;
      logic          w_got;
      logic [7:0]    wdata;
      logic          wstrb0;
      logic [1:0]    bresp;
      lrp_rd_state_t rd;
      logic [7:0]    rdata;
      logic [1:0]    rresp;
      logic [17:0]   ratio;
   } lrp_main_t;

endpackage

// ---- design/lrp_byte_cell.sv ----
`timescale 1ns/100ps
`default_nettype none

module lrp_byte_cell
   import lrp_pkg::*;
#(
   parameter logic [7:0] RST_VAL  = 8'h00,
   parameter logic [7:0] BIT_MASK = 8'hff
) (
   input  wire logic       mclk_in,    // system clock
   input  wire logic       reset_in,   // sync reset, high
   input  wire logic       ce_in,      // clock enable
   input  wire logic       wr_in,      // write strobe
   input  wire logic [7:0] wdata_in,   // write byte
   output logic      [7:0] value_out   // stored byte
);

   lrp_cell_t st_q;
   lrp_cell_t st_d;

   // ========================================================================
   // storage
   // ========================================================================
   // masking on write keeps reserved bits at zero forever
   always_comb begin
      st_d = st_q;
      if (wr_in) begin
         st_d.val = wdata_in & BIT_MASK;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         st_q <= '{val: RST_VAL};
      end else if (ce_in) begin
         st_q <= st_d;
      end
   end

   assign value_out = st_q.val;

endmodule
`default_nettype wire

// ---- design/lrp_regs_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "lrp_regs.svh"

module lrp_regs_top
   import lrp_pkg::*;
(
   input  wire logic        mclk_in,                     // 100 MHz system clock
   input  wire logic        reset_in,                    // sync reset, high
   input  wire logic        ce_in,                       // clock enable, low freezes
   input  wire logic [15:0] s_axi_awaddr_in,             // write address
   input  wire logic        s_axi_awvalid_in,            // write address valid
   output logic             s_axi_awready_out,           // write address ready
   input  wire logic [31:0] s_axi_wdata_in,              // write data
   input  wire logic [3:0]  s_axi_wstrb_in,              // write strobes
   input  wire logic        s_axi_wvalid_in,             // write data valid
   output logic             s_axi_wready_out,            // write data ready
   output logic [1:0]       s_axi_bresp_out,             // write response
   output logic             s_axi_bvalid_out,            // write response valid
   input  wire logic        s_axi_bready_in,             // write response ready
   input  wire logic [15:0] s_axi_araddr_in,             // read address
   input  wire logic        s_axi_arvalid_in,            // read address valid
   output logic             s_axi_arready_out,           // read address ready
   output logic [31:0]      s_axi_rdata_out,             // read data
   output logic [1:0]       s_axi_rresp_out,             // read response
   output logic             s_axi_rvalid_out,            // read data valid
   input  wire logic        s_axi_rready_in,             // read data ready
   output logic [1:0]       second_input_rank_out,       // selection rank, 0 highest
   output logic             second_input_use_out,        // first loop may lock
   output logic [15:0]      loop_bw_scale_out,           // bandwidth, 0.1 Hz units
   output logic             high_margin_filter_out,      // base filter select
   output logic [16:0]      integer_feedback_count_out,  // stored integer divider field
   output logic [17:0]      effective_integer_ratio_out, // stored divider plus one
   output logic [22:0]      feedback_numerator_out,      // fractional numerator
   output logic [22:0]      feedback_modulus_out         // fractional modulus
);

   localparam logic [`LRP_NUM_REGS-1:0][7:0] RST_TABLE = {
      `LRP_RST_MOD_HIGH, `LRP_RST_MOD_MID, `LRP_RST_MOD_LOW,
      `LRP_RST_NUM_HIGH, `LRP_RST_NUM_MID, `LRP_RST_NUM_LOW,
      `LRP_RST_INT_TOP,  `LRP_RST_INT_MID, `LRP_RST_INT_LOW,
      `LRP_RST_FILTER,   `LRP_RST_BW_HIGH, `LRP_RST_BW_LOW,
      `LRP_RST_RANK_USE
   };

   localparam logic [`LRP_NUM_REGS-1:0][7:0] MASK_TABLE = {
      `LRP_MASK_FRAC_HIGH, `LRP_MASK_FULL, `LRP_MASK_FULL,
      `LRP_MASK_FRAC_HIGH, `LRP_MASK_FULL, `LRP_MASK_FULL,
      `LRP_MASK_INT_TOP,   `LRP_MASK_FULL, `LRP_MASK_FULL,
      `LRP_MASK_FILTER,    `LRP_MASK_FULL, `LRP_MASK_FULL,
      `LRP_MASK_RANK_USE
   };

   lrp_main_t  st_q;
   lrp_main_t  st_d;
   logic [7:0] cell_val [`LRP_NUM_REGS];
   logic [`LRP_NUM_REGS-1:0] cell_wr;
   logic       wr_fire;
   logic       wr_hit;
   logic [3:0] wr_slot;
   logic       rd_hit;
   logic [3:0] rd_slot;
   logic [7:0] rd_byte;
   logic       aw_take;
   logic       w_take;
   logic       ar_take;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (reset_in);

   // ========================================================================
   // address decode
   // ========================================================================
   // printed offsets are word indices; anything outside the window or not
   // word aligned is unmapped and answered with SLVERR
   function automatic logic addr_hit(input logic [15:0] addr);
      logic [13:0] idx;
      idx = addr[15:2];
      if (addr[1:0] != 2'b00) begin
         return 1'b0;
      end else if (idx < `LRP_IDX_RANK_USE) begin
         return 1'b0;
      end else if (idx > `LRP_IDX_MOD_HIGH) begin
         return 1'b0;
      end else begin
         return 1'b1;
      end
   endfunction

   function automatic logic [3:0] addr_slot(input logic [15:0] addr);
      logic [13:0] diff;
      diff = addr[15:2] - `LRP_IDX_RANK_USE;
      return diff[3:0];
   endfunction

   assign wr_hit  = addr_hit(st_q.awaddr);
   assign wr_slot = addr_slot(st_q.awaddr);
   assign rd_hit  = addr_hit(s_axi_araddr_in);
   assign rd_slot = addr_slot(s_axi_araddr_in);

   // ========================================================================
   // bus handshakes
   // ========================================================================
   // every valid and ready is gated by ce so no beat is taken while frozen
   assign s_axi_awready_out = ce_in && (st_q.wr == LRP_WR_COLLECT) && !st_q.aw_got;
   assign s_axi_wready_out  = ce_in && (st_q.wr == LRP_WR_COLLECT) && !st_q.w_got;
   assign s_axi_bvalid_out  = ce_in && (st_q.wr == LRP_WR_RESP);
   assign s_axi_arready_out = ce_in && (st_q.rd == LRP_RD_IDLE);
   assign s_axi_rvalid_out  = ce_in && (st_q.rd == LRP_RD_VALID);
   assign s_axi_bresp_out   = st_q.bresp;
   assign s_axi_rresp_out   = st_q.rresp;
   assign s_axi_rdata_out   = {24'h000000, st_q.rdata};

   assign aw_take = s_axi_awvalid_in && s_axi_awready_out;
   assign w_take  = s_axi_wvalid_in && s_axi_wready_out;
   assign ar_take = s_axi_arvalid_in && s_axi_arready_out;
   assign wr_fire = ce_in && (st_q.wr == LRP_WR_COLLECT) && st_q.aw_got && st_q.w_got;

   // ========================================================================
   // register cells
   // ========================================================================
   // only byte lane 0 carries data; a write with wstrb[0] low stores nothing
   always_comb begin
      cell_wr = '0;
      for (int i = 0; i < `LRP_NUM_REGS; i++) begin
         if (wr_fire && wr_hit && st_q.wstrb0 && (wr_slot == 4'(i))) begin
            cell_wr[i] = 1'b1;
         end
      end
   end

   for (genvar g = 0; g < `LRP_NUM_REGS; g++) begin : g_cell
      lrp_byte_cell #(
         .RST_VAL  (RST_TABLE[g]),
         .BIT_MASK (MASK_TABLE[g])
      ) u_cell (
         .mclk_in   (mclk_in),
         .reset_in  (reset_in),
         .ce_in     (ce_in),
         .wr_in     (cell_wr[g]),
         .wdata_in  (st_q.wdata),
         .value_out (cell_val[g])
      );
   end

   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < `LRP_NUM_REGS; i++) begin
         if (rd_hit && (rd_slot == 4'(i))) begin
            rd_byte = cell_val[i];
         end
      end
   end

   // ========================================================================
   // next state
   // ========================================================================
   always_comb begin
      st_d = st_q;
      if (aw_take) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr_in;
      end
      if (w_take) begin
         st_d.w_got  = 1'b1;
         st_d.wdata  = s_axi_wdata_in[7:0];
         st_d.wstrb0 = s_axi_wstrb_in[0];
      end
      case (st_q.wr)
         LRP_WR_COLLECT: begin
            if (wr_fire) begin
               st_d.aw_got = 1'b0;
               st_d.w_got  = 1'b0;
               st_d.bresp  = wr_hit ? `LRP_RESP_OKAY : `LRP_RESP_SLVERR;
               st_d.wr     = LRP_WR_RESP;
            end
         end
         LRP_WR_RESP: begin
            if (s_axi_bready_in) begin
               st_d.wr = LRP_WR_COLLECT;
            end
         end
         default: begin
            st_d.wr = LRP_WR_COLLECT;
         end
      endcase
      case (st_q.rd)
         LRP_RD_IDLE: begin
            if (ar_take) begin
               st_d.rdata = rd_byte;
               st_d.rresp = rd_hit ? `LRP_RESP_OKAY : `LRP_RESP_SLVERR;
               st_d.rd    = LRP_RD_VALID;
            end
         end
         LRP_RD_VALID: begin
            if (s_axi_rready_in) begin
               st_d.rd = LRP_RD_IDLE;
            end
         end
         default: begin
            st_d.rd = LRP_RD_IDLE;
         end
      endcase
      st_d.ratio = 18'(integer_feedback_count_out) + 18'h00001;
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         st_q <= '{wr: LRP_WR_COLLECT, aw_got: 1'b0, awaddr: 16'h0000, w_got: 1'b0,
                   wdata: 8'h00, wstrb0: 1'b0, bresp: `LRP_RESP_OKAY, rd: LRP_RD_IDLE,
                   rdata: 8'h00, rresp: `LRP_RESP_OKAY,
                   ratio: 18'(`LRP_RST_INT_WORD) + 18'h00001};
      end else if (ce_in) begin
         st_q <= st_d;
      end
   end

   // ========================================================================
   // profile fields
   // ========================================================================
   // rank field
   assign second_input_rank_out = cell_val[0][`LRP_RANK_MSB:`LRP_RANK_LSB];
   assign second_input_use_out = cell_val[0][`LRP_USE_BIT];
   assign loop_bw_scale_out = {cell_val[2], cell_val[1]};
   assign high_margin_filter_out = cell_val[3][`LRP_FILTER_BIT];
   assign integer_feedback_count_out = {cell_val[6][0], cell_val[5], cell_val[4]};
   assign feedback_numerator_out = {cell_val[9][6:0], cell_val[8], cell_val[7]};
   assign feedback_modulus_out = {cell_val[12][6:0], cell_val[11], cell_val[10]};
   assign effective_integer_ratio_out = st_q.ratio;

   // ========================================================================
   // checks
   // ========================================================================
   sequence s_write_slot(int unsigned slot);
      wr_fire && wr_hit && st_q.wstrb0 && (wr_slot == 4'(slot));
   endsequence

   sequence s_both_held;
      ce_in && (st_q.wr == LRP_WR_COLLECT) && st_q.aw_got && st_q.w_got;
   endsequence

   a_rank_write: assert property (
      s_write_slot(0) |=> second_input_rank_out == $past(st_q.wdata[2:1]))
      else $error("rank field did not take written bits");

   a_use_write: assert property (
      s_write_slot(0) |=> second_input_use_out == $past(st_q.wdata[0]))
      else $error("use bit did not take written bit");

   a_use_reset: assert property (
      $past(reset_in) |-> second_input_use_out && second_input_rank_out == 2'b00)
      else $error("use bit or rank wrong after reset");

   a_bw_high_write: assert property (
      s_write_slot(2) |=> loop_bw_scale_out[15:8] == $past(st_q.wdata)
                          && $stable(loop_bw_scale_out[7:0]))
      else $error("bandwidth high byte write wrong");

   a_bw_reset: assert property (
      $past(reset_in) |-> loop_bw_scale_out == `LRP_RST_BW_WORD)
      else $error("bandwidth factor reset wrong");

   a_filter_write: assert property (
      s_write_slot(3) |=> high_margin_filter_out == $past(st_q.wdata[1])
                          && cell_val[3][0] == 1'b0)
      else $error("filter select write wrong");

   a_int_top_bit: assert property (
      s_write_slot(6) |=> integer_feedback_count_out[16] == $past(st_q.wdata[0])
                          && cell_val[6][7:1] == 7'h00)
      else $error("integer divider top bit wrong");

   a_int_reset: assert property (
      $past(reset_in) |-> integer_feedback_count_out == `LRP_RST_INT_WORD
                          && effective_integer_ratio_out == 18'h007cc)
      else $error("integer divider reset wrong");

   a_num_reserved: assert property (
      s_write_slot(9) |=> feedback_numerator_out[22:16] == $past(st_q.wdata[6:0])
                          && cell_val[9][`LRP_FRAC_RSV_BIT] == 1'b0)
      else $error("numerator top byte write wrong");

   a_num_reset: assert property (
      $past(reset_in) |-> feedback_numerator_out == 23'h000004)
      else $error("numerator reset wrong");

   a_mod_reserved: assert property (
      s_write_slot(12) |=> feedback_modulus_out[22:16] == $past(st_q.wdata[6:0])
                           && cell_val[12][`LRP_FRAC_RSV_BIT] == 1'b0)
      else $error("modulus top byte write wrong");

   a_mod_reset: assert property (
      $past(reset_in) |-> feedback_modulus_out == 23'h000005)
      else $error("modulus reset wrong");

   a_ratio_follow: assert property (
      ce_in |=>
         effective_integer_ratio_out == 18'($past(integer_feedback_count_out)) + 18'h00001)
      else $error("effective ratio not integer plus one");

   a_write_resp: assert property (
      s_both_held |=> (st_q.wr == LRP_WR_RESP) && !st_q.aw_got && !st_q.w_got)
      else $error("write response not raised after both beats");

   a_read_answer: assert property (
      ar_take |=> (st_q.rd == LRP_RD_VALID) && st_q.rdata == $past(rd_byte))
      else $error("read data not captured");

   a_slverr_write: assert property (
      wr_fire && !wr_hit |=> st_q.bresp == `LRP_RESP_SLVERR
                             && $stable(second_input_rank_out))
      else $error("unmapped write not refused");

   a_freeze_state: assert property (
      !ce_in |=> $stable(st_q) && $stable(feedback_numerator_out)
                 && $stable(feedback_modulus_out))
      else $error("state moved while clock enable low");

endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// compare helper
// ==========================================================================
`define CHK(nm, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("ERROR %s expected %h seen %h", nm, exp, got); \
      end \
   end

module tb_top;

   logic        mclk_in;
   logic        reset_in;
   logic        ce;
   logic [15:0] awaddr;
   logic [15:0] araddr;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [31:0] rdata;
   logic [1:0]  rank;
   logic        use_o;
   logic [15:0] bw;
   logic        filt;
   logic [16:0] cnt;
   logic [17:0] ratio;
   logic [22:0] num;
   logic [22:0] modu;
   int          fail_count;
   int          samples_checked;

   // reset values and writable bits, slots 0..12
   logic [7:0] rst_tbl [13] = '{8'h01, 8'hf4, 8'h01, 8'h00, 8'hcb, 8'h07, 8'h00,
                                8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
   logic [7:0] msk_tbl [13] = '{8'h07, 8'hff, 8'hff, 8'h02, 8'hff, 8'hff, 8'h01,
                                8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'h7f};

   lrp_regs_top u_dut (
      .mclk_in                     (mclk_in),
      .reset_in                    (reset_in),
      .ce_in                       (ce),
      .s_axi_awaddr_in             (awaddr),
      .s_axi_awvalid_in            (awvalid),
      .s_axi_awready_out           (awready),
      .s_axi_wdata_in              (wdata),
      .s_axi_wstrb_in              (wstrb),
      .s_axi_wvalid_in             (wvalid),
      .s_axi_wready_out            (wready),
      .s_axi_bresp_out             (bresp),
      .s_axi_bvalid_out            (bvalid),
      .s_axi_bready_in             (bready),
      .s_axi_araddr_in             (araddr),
      .s_axi_arvalid_in            (arvalid),
      .s_axi_arready_out           (arready),
      .s_axi_rdata_out             (rdata),
      .s_axi_rresp_out             (rresp),
      .s_axi_rvalid_out            (rvalid),
      .s_axi_rready_in             (rready),
      .second_input_rank_out       (rank),
      .second_input_use_out        (use_o),
      .loop_bw_scale_out           (bw),
      .high_margin_filter_out      (filt),
      .integer_feedback_count_out  (cnt),
      .effective_integer_ratio_out (ratio),
      .feedback_numerator_out      (num),
      .feedback_modulus_out        (modu)
   );

   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end

   function automatic logic [15:0] ba(input int i);
      return 16'((32'h044d + i) * 4);
   endfunction

   // ==========================================================================
   // bus tasks: payload held until its own ready is sampled high
   // ==========================================================================
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      @(posedge mclk_in);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= {24'h000000, d};
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic [1:0] r);
      @(posedge mclk_in);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      `CHK("rdata upper", 24'h000000, rdata[31:8])
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask

   // ==========================================================================
   // scenarios
   // ==========================================================================
   task automatic test_reset;
      logic [7:0] d;
      logic [1:0] r;
      for (int i = 0; i < 13; i++) begin
         rd(ba(i), d, r);
         `CHK("reset byte", rst_tbl[i], d)
         `CHK("reset resp", 2'b00, r)
      end
      `CHK("rank", 2'b00, rank)
      `CHK("use", 1'b1, use_o)
      `CHK("bw", 16'h01f4, bw)
      `CHK("filter", 1'b0, filt)
      `CHK("count", 17'h007cb, cnt)
      `CHK("ratio", 18'h007cc, ratio)
      `CHK("num", 23'h000004, num)
      `CHK("mod", 23'h000005, modu)
   endtask

   // all ones then all zeros: reserved bits must stay clear
   task automatic test_masks;
      logic [7:0] d;
      logic [1:0] r;
      for (int v = 0; v < 2; v++) begin
         for (int i = 0; i < 13; i++) begin
            wr(ba(i), (v == 0) ? 8'hff : 8'h00, 4'hf, r); // high margin, wide bandwidth on the all-ones pass
            `CHK("wr resp", 2'b00, r)
         end
         for (int i = 0; i < 13; i++) begin
            rd(ba(i), d, r);
            `CHK("masked byte", (v == 0) ? msk_tbl[i] : 8'h00, d)
         end
         `CHK("rank", (v == 0) ? 2'b11 : 2'b00, rank)
         `CHK("use", (v == 0), use_o)
         `CHK("bw", (v == 0) ? 16'hffff : 16'h0000, bw)
         `CHK("filter", (v == 0), filt)
         `CHK("count", (v == 0) ? 17'h1ffff : 17'h00000, cnt)
         `CHK("ratio", (v == 0) ? 18'h20000 : 18'h00001, ratio)
         `CHK("num", (v == 0) ? 23'h7fffff : 23'h000000, num)
         `CHK("mod", (v == 0) ? 23'h7fffff : 23'h000000, modu)
      end
   endtask

   // every rank code with both use settings, then distinct bytes for lane order
   task automatic test_fields;
      logic [1:0] r;
      logic [7:0] d;
      for (int k = 0; k < 8; k++) begin
         wr(ba(0), 8'(k), 4'h1, r);
         `CHK("rank", 2'(k >> 1), rank)
         `CHK("use", k[0], use_o)
      end
      wr(ba(1), 8'h88, 4'h1, r); // 500 Hz loop bandwidth
      wr(ba(2), 8'h13, 4'h1, r);
      wr(ba(4), 8'h34, 4'h1, r);
      wr(ba(5), 8'h12, 4'h1, r);
      wr(ba(6), 8'h01, 4'h1, r);
      wr(ba(7), 8'h56, 4'h1, r);
      wr(ba(8), 8'h34, 4'h1, r);
      wr(ba(9), 8'h92, 4'h1, r);
      wr(ba(10), 8'h9a, 4'h1, r);
      wr(ba(11), 8'h78, 4'h1, r);
      wr(ba(12), 8'h85, 4'h1, r);
      rd(ba(9), d, r);
      `CHK("num top byte", 8'h12, d)
      `CHK("bw", 16'h1388, bw)
      `CHK("count", 17'h11234, cnt)
      `CHK("ratio", 18'h11235, ratio)
      `CHK("num", 23'h123456, num)
      `CHK("mod", 23'h05789a, modu)
   endtask

   // refused accesses must leave the stored byte alone
   task automatic test_errors;
      logic [1:0] r;
      logic [7:0] d;
      wr(ba(13), 8'h55, 4'hf, r);
      `CHK("unmapped wr", 2'b10, r)
      rd(ba(-1), d, r);
      `CHK("unmapped rd resp", 2'b10, r)
      `CHK("unmapped rd data", 8'h00, d)
      wr(ba(0) + 16'h0001, 8'h00, 4'hf, r);
      `CHK("unaligned wr", 2'b10, r)
      wr(ba(0), 8'h00, 4'he, r);
      `CHK("no strobe wr", 2'b00, r)
      rd(ba(0), d, r);
      `CHK("kept byte", 8'h07, d)
      ce <= 1'b0;
      @(posedge mclk_in);
      @(posedge mclk_in);
      `CHK("frozen arready", 1'b0, arready)
      `CHK("frozen awready", 1'b0, awready)
      ce <= 1'b1;
   endtask

   // ==========================================================================
   // end of run
   // ==========================================================================
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // a few hundred bus cycles are expected; this is a generous margin
   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      complete_run();
   end

   initial begin
      fail_count      = 0;
      samples_checked = 0;
      reset_in        = 1'b1;
      ce              = 1'b1;
      awaddr          = 16'h0000;
      araddr          = 16'h0000;
      awvalid         = 1'b0;
      wvalid          = 1'b0;
      bready          = 1'b0;
      arvalid         = 1'b0;
      rready          = 1'b0;
      wdata           = 32'h00000000;
      wstrb           = 4'h0;
      repeat (20) @(posedge mclk_in);
      reset_in <= 1'b0;
      test_reset();
      test_masks();
      test_fields();
      test_errors();
      // second reset while fields hold non-default values
      reset_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      reset_in <= 1'b0;
      test_reset();
      complete_run();
   end

endmodule

`default_nettype wire
